// *** shared/rscf_pkg.sv ***
package rscf_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map, word aligned byte offsets
   localparam logic [7:0]  OFS_FLAGS      = 8'h00;  // reset_cause_flags
   localparam logic [7:0]  OFS_OSC_CTRL   = 8'h04;  // oscillator_control_reg
   localparam logic [7:0]  OFS_STATUS     = 8'h08;  // sequencer status

   ////////////////////////////////////////////////////////////////////////////
   // Reset cause flag positions
   localparam int          FB_TRAP        = 15;     // trap_conflict_flag
   localparam int          FB_ILLEGAL     = 14;     // illegal_access_flag
   localparam int          FB_PIN         = 7;      // pin_reset_flag
   localparam int          FB_SOFT        = 6;      // soft_reset_flag
   localparam int          FB_WATCHDOG    = 4;      // watchdog_expiry_flag
   localparam int          FB_SLEEP       = 3;
   localparam int          FB_IDLE        = 2;
   localparam int          FB_SUPPLY_DIP  = 1;
   localparam int          FB_POWER_ON    = 0;

   // Implemented bits; the rest read as zero
   localparam logic [15:0] FLAGS_IMPL     = 16'hC0DF;
   // Bits a supply dip clears, and the wider set power-on clears
   localparam logic [15:0] DIP_CLEAR      = 16'hC05C;
   localparam logic [15:0] PWR_CLEAR      = 16'hC0DC;
   // Flags after the block's own reset: power-on and supply dip
   localparam logic [15:0] FLAGS_RESET    = 16'h0003;

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator control fields
   localparam int          OC_CUR_LSB     = 12;     // current_clock_field 14:12
   localparam int          OC_NEXT_LSB    = 8;      // requested source 10:8
   localparam int          OC_SWITCH_BIT  = 0;      // switch request / busy

   // Status fields
   localparam int          SR_IN_RESET    = 0;
   localparam int          SR_COLD        = 1;
   localparam int          SR_SWITCH      = 2;
   localparam int          SR_STATE_LSB   = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Clock source codes
   localparam logic [2:0]  CLK_FAST_RC       = 3'h0;
   localparam logic [2:0]  CLK_FAST_RC_PLL   = 3'h1;
   localparam logic [2:0]  CLK_PRIMARY       = 3'h2;
   localparam logic [2:0]  CLK_PRIMARY_PLL   = 3'h3;
   localparam logic [2:0]  CLK_LP_RC         = 3'h5;
   localparam logic [2:0]  CLK_FAST_RC_DIV16 = 3'h6;
   localparam logic [2:0]  CLK_FAST_RC_DIVN  = 3'h7;
   localparam logic [2:0]  CLK_RESET         = 3'h0;

   // Primary oscillator kind
   localparam logic [1:0]  PRI_EXT_CLOCK     = 2'h0;  // external_clock_mode
   localparam logic [1:0]  PRI_CRYSTAL       = 2'h1;  // crystal_mode
   localparam logic [1:0]  PRI_FAST_CRYSTAL  = 2'h2;  // high_speed_crystal_mode

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int unsigned CLK_PERIOD_NS     = 25;
   localparam int unsigned TOSCD_FAST_RC_NS  = 1100;
   localparam int unsigned TOSCD_LP_RC_NS    = 70000;
   localparam int unsigned TLOCK_NS          = 1500000;
   localparam int unsigned TIMER_CYCLES      = 1024;
   localparam int unsigned FAST_RC_CYCLES    =
      (TOSCD_FAST_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LP_RC_CYCLES      =
      (TOSCD_LP_RC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned LOCK_CYCLES_DEF   =
      (TLOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CNT_W             = 17;

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      SQ_RUN    = 5'h01,
      SQ_SUPPLY = 5'h02,
      SQ_OSCD   = 5'h04,
      SQ_TIMER  = 5'h08,
      SQ_LOCK   = 5'h10
   } rscf_seq_t;

   typedef struct packed {
      rscf_seq_t          st;
      logic [CNT_W-1:0]   cnt;
   } rscf_step_t;

   typedef struct packed {
      rscf_seq_t          st;
      logic [CNT_W-1:0]   cnt;
      logic [2:0]         cur_clk;
      logic [2:0]         next_clk;
      logic               switch_busy;
      logic               in_reset;
      logic               cold;
      logic [15:0]        flags;
      logic               wr_pend;
      logic [7:0]         wr_ofs;
      logic [31:0]        hrdata;
      logic               hready;
   } rscf_state_t;

endpackage

// *** verification/rscf_osc_model.sv ***
`timescale 1ns/1ps
module rscf_osc_model #(
   parameter int SUP_DLY = 16,  // Supply settle cycles
   parameter int OSC_DLY = 30   // Crystal start cycles
) (
   input  wire logic ref_clk_i,   // Clock
   input  wire logic rst_i,       // Power applied
   input  wire logic dip_i,       // Commanded supply dip
   output logic      supply_ok_o, // Supplies stable
   output logic      osc_ready_o  // Crystal running
);
   int cnt_q = 0;

   // Supplies settle first, crystal later; a dip restarts both
   always_ff @(posedge ref_clk_i) begin
      if (rst_i || dip_i) cnt_q <= 0;
      else if (cnt_q < SUP_DLY + OSC_DLY) cnt_q <= cnt_q + 1;
   end
   assign supply_ok_o = cnt_q >= SUP_DLY && !dip_i;
   assign osc_ready_o = cnt_q >= SUP_DLY + OSC_DLY;
endmodule

// *** verification/rscf_reset_seq_bench.sv ***
`timescale 1ns/1ps
module rscf_reset_seq_bench;
   import rscf_pkg::*;
   localparam int unsigned LOCK = 20;
   logic        ref_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [9:0]  ev = '0;
   logic [2:0]  boot = CLK_FAST_RC;
   logic [1:0]  kind = PRI_CRYSTAL;
   logic        dip = 1'b0;
   logic [31:0] hrdata, rd;
   logic        hready, hresp, supply_ok, osc_ready, sys_reset;
   logic [2:0]  clk_src;
   int          bad_count = 0;
   int          checks = 0;
   int          ev_idx[7] = '{2, 3, 4, 5, 6, 8, 9};
   int          ev_bit[7] = '{FB_PIN, FB_SOFT, FB_TRAP, FB_ILLEGAL, FB_WATCHDOG, FB_SLEEP, FB_IDLE};
   logic [2:0]  m_clk[7] = '{CLK_FAST_RC, CLK_LP_RC, CLK_FAST_RC_PLL, CLK_PRIMARY,
                             CLK_PRIMARY_PLL, CLK_PRIMARY, CLK_PRIMARY_PLL};
   logic [1:0]  m_kind[7] = '{PRI_CRYSTAL, PRI_CRYSTAL, PRI_CRYSTAL, PRI_CRYSTAL,
                              PRI_FAST_CRYSTAL, PRI_EXT_CLOCK, PRI_EXT_CLOCK};

   // Clock, 25 ns period
   initial forever #12.5 ref_clk_i = ~ref_clk_i;

   rscf_reset_seq #(.LOCK_CYCLES(LOCK)) i_rscf_reset_seq (
      .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .power_on_i(ev[0]), .supply_dip_reset_i(ev[1]), .master_clear_pin_i(ev[2]),
      .soft_reset_i(ev[3]), .trap_conflict_i(ev[4]), .illegal_access_i(ev[5]),
      .watchdog_expiry_i(ev[6]), .watchdog_clear_i(ev[7]), .sleep_enter_i(ev[8]),
      .idle_enter_i(ev[9]), .boot_clock_select_bits_i(boot), .primary_kind_i(kind),
      .supply_ok_i(supply_ok), .osc_ready_i(osc_ready), .sys_reset_o(sys_reset),
      .clock_source_o(clk_src));

   rscf_osc_model i_rscf_osc_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .dip_i(dip),
      .supply_ok_o(supply_ok), .osc_ready_o(osc_ready));

   ////////////////////////////////////////////////////////////////////////////
   // Compare and count; four-state so unknowns never match
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One AHB-Lite single word transfer; read data lands in rd
   task automatic bus(input logic wr, input logic [7:0] ofs, input logic [31:0] wd);
      @(posedge ref_clk_i);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= 32'(ofs);
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge ref_clk_i); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wait_run();
      @(posedge ref_clk_i);
      while (sys_reset !== 1'b0) @(posedge ref_clk_i);
   endtask

   // One-cycle event pulse; cold events also dip the supplies
   task automatic fire(input int n, input logic cold);
      @(posedge ref_clk_i);
      ev[n] <= 1'b1;
      dip <= cold;
      @(posedge ref_clk_i);
      ev <= '0;
      dip <= 1'b0;
      wait_run();
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Hang guard, well beyond the longest expected run
   initial begin
      repeat (60000) @(posedge ref_clk_i);
      bad_count++;
      give_verdict();
   end

   initial begin
      repeat (12) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      wait_run();
      bus(0, OFS_FLAGS, '0);
      check("flags after power up", 32'h0000_0003, rd);
      check("response", 32'h0, 32'(hresp));
      bus(1, OFS_FLAGS, 32'hFFFF_FFFF);
      bus(0, OFS_FLAGS, '0);
      check("flags all written", 32'h0000_C0DF, rd);
      bus(1, OFS_FLAGS, '0);
      bus(0, OFS_FLAGS, '0);
      check("flags cleared", 32'h0, rd);
      bus(1, 8'h40, 32'hFFFF_FFFF);
      bus(0, 8'h40, '0);
      check("unmapped word", 32'h0, rd);
      // Each warm and power-save cause on its own, cleared after reading
      for (int i = 0; i < 7; i++) begin
         fire(ev_idx[i], 1'b0);
         bus(0, OFS_FLAGS, '0);
         check("cause flag", 32'h1 << ev_bit[i], rd);
         bus(1, OFS_FLAGS, '0);
      end
      fire(6, 1'b0);
      fire(7, 1'b0);
      fire(8, 1'b0);
      bus(0, OFS_FLAGS, '0);
      check("watchdog flag cleared", 32'h0000_0008, rd);
      fire(2, 1'b0);
      fire(3, 1'b0);
      bus(0, OFS_FLAGS, '0);
      check("causes accumulate", 32'h0000_00C8, rd);
      bus(1, OFS_FLAGS, 32'h0000_C0DF);
      fire(1, 1'b1);
      bus(0, OFS_FLAGS, '0);
      check("flags after supply dip", 32'h0000_0083, rd);
      bus(1, OFS_FLAGS, 32'h0000_C0DC);
      fire(0, 1'b1);
      bus(0, OFS_FLAGS, '0);
      check("flags after power on", 32'h0000_0003, rd);
      // Cold resets take the boot code, warm ones keep the running source
      for (int i = 0; i < 7; i++) begin
         boot <= m_clk[i];
         kind <= m_kind[i];
         fire(0, 1'b1);
         check("clock after cold", 32'(m_clk[i]), 32'(clk_src));
         boot <= CLK_FAST_RC_DIV16;
         fire(3, 1'b0);
         check("clock after warm", 32'(m_clk[i]), 32'(clk_src));
         bus(0, OFS_OSC_CTRL, '0);
         check("current clock field", 32'(m_clk[i]), 32'(rd[14:12]));
      end
      // Clock switch runs the waits without reset; status shows progress
      bus(1, OFS_OSC_CTRL, 32'h0000_0601);
      bus(0, OFS_STATUS, '0);
      check("status while switching", 32'h0000_0404, rd);
      repeat (60) @(posedge ref_clk_i);
      bus(0, OFS_OSC_CTRL, '0);
      check("control after switch", 32'h0000_6600, rd);
      check("clock after switch", 32'(CLK_FAST_RC_DIV16), 32'(clk_src));
      give_verdict();
   end
endmodule

// *** verification/rscf_reset_seq_sva.sv ***
`timescale 1ns/1ps
module rscf_reset_seq_chk
   import rscf_pkg::*;
#(
   parameter int unsigned LOCK_CYCLES = 20  // PLL lock wait
) (
   input wire logic       ref_clk_i,          // Clock
   input wire logic       rst_i,              // Sync reset
   input wire logic       power_on_i,         // Cold event
   input wire logic       supply_dip_reset_i, // Cold event
   input wire logic       master_clear_pin_i, // Warm event
   input wire logic       soft_reset_i,       // Warm event
   input wire logic       trap_conflict_i,    // Warm event
   input wire logic       illegal_access_i,   // Warm event
   input wire logic       watchdog_expiry_i,  // Warm event
   input wire logic [1:0] primary_kind_i,     // Primary kind
   input wire logic       supply_ok_i,        // Supplies stable
   input wire logic       sys_reset_o,        // Reset hold
   input wire logic [2:0] clock_source_o      // Clock code
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   logic [16:0] hold_q;
   logic [16:0] hold_d;
   logic        warm;
   logic        ext;

   // Cycles held in reset with good supplies; restarts add cycles, so the external clock upper bounds assume none
   always_comb begin
      hold_d = sys_reset_o ? hold_q + 17'(supply_ok_i) : '0;
   end
   always_ff @(posedge ref_clk_i) begin
      hold_q <= rst_i ? '0 : hold_d;
   end
   assign warm = master_clear_pin_i | soft_reset_i | trap_conflict_i
               | illegal_access_i | watchdog_expiry_i;
   assign ext = primary_kind_i == PRI_EXT_CLOCK;

   ////////////////////////////////////////////////////////////////////////////
   property p_cold_enter; power_on_i || supply_dip_reset_i |=> sys_reset_o; endproperty
   a_cold_enter: assert property (p_cold_enter) else $error("cold event not held");
   property p_warm_enter; warm |=> sys_reset_o; endproperty
   a_warm_enter: assert property (p_warm_enter) else $error("warm event not held");
   property p_supply_hold; sys_reset_o && !supply_ok_i |=> sys_reset_o; endproperty
   a_supply_hold: assert property (p_supply_hold) else $error("released on bad supply");
   property p_fast_wait;
      $fell(sys_reset_o) && clock_source_o == CLK_FAST_RC |-> hold_q >= FAST_RC_CYCLES;
   endproperty
   a_fast_wait: assert property (p_fast_wait) else $error("fast rc delay short");
   property p_lp_wait;
      $fell(sys_reset_o) && clock_source_o == CLK_LP_RC |-> hold_q >= LP_RC_CYCLES;
   endproperty
   a_lp_wait: assert property (p_lp_wait) else $error("low power rc delay short");
   property p_timer_wait;
      $fell(sys_reset_o) && clock_source_o == CLK_PRIMARY && !ext |-> hold_q >= TIMER_CYCLES;
   endproperty
   a_timer_wait: assert property (p_timer_wait) else $error("start-up timer short");
   property p_lock_wait;
      $fell(sys_reset_o) && clock_source_o == CLK_PRIMARY_PLL && !ext
         |-> hold_q >= TIMER_CYCLES + LOCK_CYCLES;
   endproperty
   a_lock_wait: assert property (p_lock_wait) else $error("lock wait short");
   property p_ext_nowait;
      $fell(sys_reset_o) && clock_source_o == CLK_PRIMARY && ext |-> hold_q <= 4;
   endproperty
   a_ext_nowait: assert property (p_ext_nowait) else $error("external clock waited");
   property p_ext_lock;
      $fell(sys_reset_o) && clock_source_o == CLK_PRIMARY_PLL && ext
         |-> hold_q >= LOCK_CYCLES && hold_q <= LOCK_CYCLES + 4;
   endproperty
   a_ext_lock: assert property (p_ext_lock) else $error("external pll wait wrong");
   property p_warm_keep; soft_reset_i && !sys_reset_o |=> $stable(clock_source_o) [*8];
   endproperty
   a_warm_keep: assert property (p_warm_keep) else $error("warm reset moved clock");
endmodule

bind rscf_reset_seq rscf_reset_seq_chk #(.LOCK_CYCLES(LOCK_CYCLES)) i_rscf_reset_seq_chk (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .power_on_i(power_on_i),
   .supply_dip_reset_i(supply_dip_reset_i), .master_clear_pin_i(master_clear_pin_i),
   .soft_reset_i(soft_reset_i), .trap_conflict_i(trap_conflict_i),
   .illegal_access_i(illegal_access_i), .watchdog_expiry_i(watchdog_expiry_i),
   .primary_kind_i(primary_kind_i), .supply_ok_i(supply_ok_i),
   .sys_reset_o(sys_reset_o), .clock_source_o(clock_source_o));

// *** verilog/rscf_reset_seq.sv ***
// The placing of the registers and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
// What this block does
// - Power-on or supply dip means cold reset
// - Cold reset takes clock from boot selection
// - All other sources, soft reset included, are warm
// - Warm reset keeps current clock field source
// - Hold reset until supply stable, clock ready
// - Crystal: delay, timer; RC: delay; external clock: none; PLL adds lock
// - Start-up timer counts 1024 clock periods
// - PLL adds 1.5 ms lock wait
// - Start-up delay 1.1 us fast, 70 us low-power
// - Software can read cause flags after reset
// - Bit 15 trap conflict; cold clears
// - Bit 14 illegal access; cold clears
// - Bit 7 pin reset; only power-on clears
// - Bit 6 soft reset; cold clears
// - Bit 4 watchdog; power-save, clear, cold clear
// - Bit 3 sleep entry; cold clears
// - Bit 2 idle entry; cold clears
// - Bit 1 dip/power-on, bit 0 power-on
// - Software may set or clear any flag
module rscf_reset_seq #(
   parameter int unsigned LOCK_CYCLES = rscf_pkg::LOCK_CYCLES_DEF  // PLL lock wait
) (
   input  wire logic        ref_clk_i,            // Oscillator clock
   input  wire logic        rst_i,                // Sync reset, active high
   // AHB-Lite slave
   input  wire logic        hsel_i,               // Slave select
   input  wire logic [31:0] haddr_i,              // Byte address
   input  wire logic [1:0]  htrans_i,             // Transfer type
   input  wire logic        hwrite_i,             // Write when high
   input  wire logic [2:0]  hsize_i,              // Word only
   input  wire logic [31:0] hwdata_i,             // Write data
   input  wire logic        hready_i,             // Bus ready
   output logic      [31:0] hrdata_o,             // Read data
   output logic             hreadyout_o,          // Always ready
   output logic             hresp_o,              // Always OKAY
   // Reset sources, then watchdog-clear and power-save events; one-cycle pulses
   input  wire logic        power_on_i,           // Power-on event
   input  wire logic        supply_dip_reset_i,   // Brown-out event
   input  wire logic        master_clear_pin_i,   // External pin reset
   input  wire logic        soft_reset_i,         // Reset instruction
   input  wire logic        trap_conflict_i,      // Trap conflict
   input  wire logic        illegal_access_i,     // Illegal opcode / W use
   input  wire logic        watchdog_expiry_i,    // Watchdog time-out
   input  wire logic        watchdog_clear_i,     // Watchdog-clear instr.
   input  wire logic        sleep_enter_i,        // Power-save to sleep
   input  wire logic        idle_enter_i,         // Power-save to idle
   // Oscillator side
   input  wire logic [2:0]  boot_clock_select_bits_i, // From config word
   input  wire logic [1:0]  primary_kind_i,       // Primary oscillator kind
   input  wire logic        supply_ok_i,          // Supplies stable
   input  wire logic        osc_ready_i,          // Crystal running
   output logic             sys_reset_o,          // Hold device in reset
   output logic      [2:0]  clock_source_o        // Active clock source
);
   import rscf_pkg::*;

   rscf_state_t s_q;
   rscf_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // Mode decoding helpers
   function automatic logic is_pll(input logic [2:0] c);
      return (c == CLK_FAST_RC_PLL) || (c == CLK_PRIMARY_PLL);
   endfunction

   function automatic logic is_primary(input logic [2:0] c);
      return (c == CLK_PRIMARY) || (c == CLK_PRIMARY_PLL);
   endfunction

   function automatic logic is_crystal(input logic [2:0] c, input logic [1:0] k);
      return is_primary(c) && (k != PRI_EXT_CLOCK);
   endfunction

   // Next stage of the wait chain after stage f; skipped stages fall through
   function automatic rscf_step_t plan_from(input rscf_seq_t  f,
                                            input logic [2:0] c,
                                            input logic [1:0] k);
      rscf_step_t r;
      r.st  = SQ_RUN;
      r.cnt = '0;
      if ((f == SQ_SUPPLY) && !(is_primary(c) && !is_crystal(c, k))) begin
         r.st = SQ_OSCD;
         if (c == CLK_LP_RC) begin
            r.cnt = CNT_W'(LP_RC_CYCLES - 1);
         end else if (!is_primary(c)) begin
            r.cnt = CNT_W'(FAST_RC_CYCLES - 1);
         end
      end else if (((f == SQ_SUPPLY) || (f == SQ_OSCD)) && is_crystal(c, k)) begin
         r.st  = SQ_TIMER;
         r.cnt = CNT_W'(TIMER_CYCLES - 1);
      end else if ((f != SQ_LOCK) && is_pll(c)) begin
         r.st  = SQ_LOCK;
         r.cnt = CNT_W'(LOCK_CYCLES - 1);
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      logic        take;
      logic        wr_flags;
      logic        wr_osc;
      logic        cold_ev;
      logic        warm_ev;
      logic        power_save;
      logic [15:0] f;
      logic [2:0]  tgt;
      rscf_step_t  nx;
      take       = 1'b0;
      wr_flags   = 1'b0;
      wr_osc     = 1'b0;
      cold_ev    = 1'b0;
      warm_ev    = 1'b0;
      power_save = 1'b0;
      f          = '0;
      tgt        = '0;
      nx         = '{st: SQ_RUN, cnt: '0};
      s_d        = s_q;

      // Bus address phase; zero wait states, so hready is always high
      take      = hsel_i && htrans_i[1] && hready_i;
      s_d.hready  = 1'b1;
      s_d.wr_pend = take && hwrite_i;
      s_d.wr_ofs  = haddr_i[7:0];
      if (take && !hwrite_i) begin
         case (haddr_i[7:0])
            OFS_FLAGS:    s_d.hrdata = {16'h0000, s_q.flags};
            OFS_OSC_CTRL: begin
               s_d.hrdata = '0;
               s_d.hrdata[OC_CUR_LSB +: 3]  = s_q.cur_clk;
               s_d.hrdata[OC_NEXT_LSB +: 3] = s_q.next_clk;
               s_d.hrdata[OC_SWITCH_BIT]    = s_q.switch_busy;
            end
            OFS_STATUS:   begin
               s_d.hrdata = '0;
               s_d.hrdata[SR_IN_RESET]         = s_q.in_reset;
               s_d.hrdata[SR_COLD]             = s_q.cold;
               s_d.hrdata[SR_SWITCH]           = s_q.switch_busy;
               s_d.hrdata[SR_STATE_LSB +: 5]   = s_q.st;
            end
            default:      s_d.hrdata = '0;  // Unmapped reads zero, OKAY
         endcase
      end

      // Data phase of a write lands here
      wr_flags = s_q.wr_pend && (s_q.wr_ofs == OFS_FLAGS);
      wr_osc   = s_q.wr_pend && (s_q.wr_ofs == OFS_OSC_CTRL);

      cold_ev    = power_on_i || supply_dip_reset_i;
      warm_ev    = master_clear_pin_i || soft_reset_i || trap_conflict_i
                   || illegal_access_i || watchdog_expiry_i;
      power_save = sleep_enter_i || idle_enter_i;

      // Flags: software write, then hardware clears, then hardware sets,
      // so an event in the clearing cycle is never lost
      f = s_q.flags;
      if (wr_flags) begin
         f = hwdata_i[15:0];
      end
      if (power_on_i) begin
         f = f & ~PWR_CLEAR;
      end else if (supply_dip_reset_i) begin
         f = f & ~DIP_CLEAR;
      end
      if (power_save || watchdog_clear_i) begin
         f[FB_WATCHDOG] = 1'b0;
      end
      if (trap_conflict_i)    f[FB_TRAP]       = 1'b1;
      if (illegal_access_i)   f[FB_ILLEGAL]    = 1'b1;
      if (master_clear_pin_i) f[FB_PIN]        = 1'b1;
      if (soft_reset_i)       f[FB_SOFT]       = 1'b1;
      if (watchdog_expiry_i)  f[FB_WATCHDOG]   = 1'b1;
      if (sleep_enter_i)      f[FB_SLEEP]      = 1'b1;
      if (idle_enter_i)       f[FB_IDLE]       = 1'b1;
      if (cold_ev)            f[FB_SUPPLY_DIP] = 1'b1;
      if (power_on_i)         f[FB_POWER_ON]   = 1'b1;
      s_d.flags = f & FLAGS_IMPL;

      // Sequencer stepping
      case (s_q.st)
         SQ_RUN: begin
            if (wr_osc && hwdata_i[OC_SWITCH_BIT] && !s_q.in_reset) begin
               // Clock switch runs the same waits without asserting reset
               s_d.next_clk    = hwdata_i[OC_NEXT_LSB +: 3];
               s_d.cur_clk     = hwdata_i[OC_NEXT_LSB +: 3];
               nx              = plan_from(SQ_SUPPLY, hwdata_i[OC_NEXT_LSB +: 3],
                                           primary_kind_i);
               s_d.st          = nx.st;
               s_d.cnt         = nx.cnt;
               s_d.switch_busy = (nx.st != SQ_RUN);
            end else if (wr_osc) begin
               s_d.next_clk = hwdata_i[OC_NEXT_LSB +: 3];
            end
         end
         SQ_SUPPLY: begin
            if (supply_ok_i) begin
               tgt = s_q.cold ? boot_clock_select_bits_i
                              : s_q.cur_clk;
               s_d.cur_clk = tgt;
               nx          = plan_from(SQ_SUPPLY, tgt, primary_kind_i);
               s_d.st      = nx.st;
               s_d.cnt     = nx.cnt;
            end
         end
         SQ_OSCD: begin
            // Crystal start-up ends on the ready signal, RC ones on count
            if (is_crystal(s_q.cur_clk, primary_kind_i) ? osc_ready_i
                                                        : (s_q.cnt == '0)) begin
               nx      = plan_from(SQ_OSCD, s_q.cur_clk, primary_kind_i);
               s_d.st  = nx.st;
               s_d.cnt = nx.cnt;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         SQ_TIMER: begin
            if (s_q.cnt == '0) begin
               nx      = plan_from(SQ_TIMER, s_q.cur_clk, primary_kind_i);
               s_d.st  = nx.st;
               s_d.cnt = nx.cnt;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         SQ_LOCK: begin
            if (s_q.cnt == '0) begin
               s_d.st = SQ_RUN;
            end else begin
               s_d.cnt = s_q.cnt - CNT_W'(1);
            end
         end
         default: begin
            s_d.st  = SQ_SUPPLY;
            s_d.cnt = '0;
         end
      endcase

      // Reaching run releases reset and ends any switch
      if (s_d.st == SQ_RUN) begin
         s_d.in_reset    = 1'b0;
         s_d.switch_busy = 1'b0;
      end

      // A new reset restarts the chain; a cold one stays cold until done
      if (cold_ev || warm_ev) begin
         s_d.st          = SQ_SUPPLY;
         s_d.cnt         = '0;
         s_d.in_reset    = 1'b1;
         s_d.switch_busy = 1'b0;
         s_d.cold        = cold_ev || (s_q.in_reset && s_q.cold);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register; reset acts as a power-on, so the chain starts cold
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         s_q.st          <= SQ_SUPPLY;
         s_q.cnt         <= '0;
         s_q.cur_clk     <= CLK_RESET;
         s_q.next_clk    <= CLK_RESET;
         s_q.switch_busy <= 1'b0;
         s_q.in_reset    <= 1'b1;
         s_q.cold        <= 1'b1;
         s_q.flags       <= FLAGS_RESET;
         s_q.wr_pend     <= 1'b0;
         s_q.wr_ofs      <= '0;
         s_q.hrdata      <= '0;
         s_q.hready      <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from flops, except hresp_o tied low
   assign hrdata_o       = s_q.hrdata;
   assign hreadyout_o    = s_q.hready;
   assign hresp_o        = 1'b0;  // OKAY only
   assign sys_reset_o    = s_q.in_reset;
   assign clock_source_o = s_q.cur_clk;

endmodule
